// *** rtl/thermal_defines.svh ***
// offsets, field positions, reset values and fixed constants for the thermal block
`ifndef THERMAL_DEFINES_SVH
`define THERMAL_DEFINES_SVH
`define ADDR_THERMAL_CONTROL  8'h00
`define ADDR_CAPABILITY       8'h04
`define ADDR_TRIP_STATUS      8'h08
`define ADDR_TEMP_REPORT      8'h0c
`define ADDR_SENSOR_IF        8'h10
`define ADDR_INT_STATUS       8'h14
`define ADDR_INT_MASK         8'h18
`define CTL_EN_BIT            0
`define CTL_ACT_BIT           4
`define CTL_HOT_BIT           5
`define CTL_PSTATE_LSB        28
`define CTL_LIMIT_LSB         16
`define CTL_HYST_LSB          24
`define CAP_THROTTLE_BIT      10
`define TRIP_SUPPORT_BIT      5
`define TRIP_STATE_BIT        0
`define TEMP_LSB              21
`define SIF_STD_BIT           0
`define SIF_FAST_BIT          1
`define RST_LIMIT             11'h000
`define RST_HYST              4'h0
`define RST_PSTATE            3'h0
`define RST_SIF               2'h1
`define RST_IRQ_MASK          4'h0
`define DAMAGE_TEMP           11'h7f8
`define LOW_VID               8'h7f
`define IRQ_ENTER_BIT         0
`define IRQ_EXIT_BIT          1
`define IRQ_TRIP_BIT          2
`define IRQ_HOT_BIT           3
`endif

// *** rtl/thermal_pkg.sv ***
// types for the thermal throttle and trip block
package thermal_pkg;
  typedef logic [10:0] temp_t; // 8.3 unsigned fixed point
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_THROTTLE,
    ST_TRIP
  } therm_state_t;
  typedef struct packed {
    logic        we;
    logic        re;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;
  typedef struct packed {
    therm_state_t state;
    logic         en;
    logic [2:0]   pstate_lim;
    temp_t        limit;
    logic [3:0]   hyst;
    logic         armed;
    logic         internal;
    logic [1:0]   sif_mode;
    logic [3:0]   irq_sts;
    logic [3:0]   irq_msk;
    logic [31:0]  rdata;
    logic         hot_s1;
    logic         hot_s2;
    logic         pg_s1;
    logic         pg_s2;
    logic         irq;
    logic         hot_oe_n;
    logic         oe_d1;
    logic         oe_d2;
    logic         trip_n;
    logic         gate;
    logic [7:0]   voltage_identification_code;
    logic         limit_act;
    temp_t        temp;
  } therm_st_t;
endpackage

// *** rtl/thermal_throttle_and_trip.sv ***
// hardware thermal throttle, hot pin handling and thermal trip latch
// register map, byte offsets on the plain register port
//   0x00 control: b0 enable, b4 active, b5 hot pin seen, [22:16] limit, [27:24] hysteresis, [30:28] perf cap
//   0x04 capability: b10 throttle capable
//   0x08 trip: b0 trip latched, b5 trip supported
//   0x0c temperature report: [31:21] control temperature
//   0x10 sensor interface speed: b0 standard, b1 fast; writing zero falls back to standard
//   0x14 event status, write one to clear: b0 enter, b1 exit, b2 trip, b3 external hot
//   0x18 event mask, same layout as status
//
// temperature scale, 8.3 unsigned: limit field sits at bits 10:4, hysteresis counts whole units
// a value below the limit reads as distance under maximum, at or above it as excess
// own drive of the hot pin is masked for two extra cycles so the synchroniser echo
// of a release is not mistaken for an external assertion
//
// timing, in clock edges after the input changes:
//   temperature: one edge into the sample register, one into the state, outputs with it
//   hot pin and power good: two synchroniser edges, then the state edge
//   read data: stands only in the cycle after the read strobe
//   event status: a new event in the same cycle as its clear keeps the bit set
//   trip: entered at 255.0 in the 8.3 scale, left only by the cold reset
//   throttle with enable cleared: held while the pin is asserted from outside
//   perf cap: the limit field reaches the cores at all times, whether or not throttling is active
//   interrupt: level, high while any unmasked status bit is set
//   sensor copy: the sampled temperature, one edge behind the input
// limitations and usage:
//   while the block pulls the hot pin itself it cannot see an outside assertion
//   the high speed sideband mode has no encoding and cannot be chosen
//   only the enable bit of the control word may change while throttling
//   power good: throttling cannot start until it has passed both flops
//   c-states are checked in the same cycle; they block entry and never force exit
//   capability and trip support are fixed by parameters and read back as such
//   the damage threshold and low voltage code are fixed constants of the build
//   a zero hysteresis lets the block leave as soon as it drops under the limit
//   the limit field counts in steps of two whole degrees
//   irq mask resets to zero, so no event interrupts until software opens it
//   the sideband speed register resets to standard mode
`timescale 1ns/1ns
`include "thermal_defines.svh"
// THROTTLE_CAPABLE reports whether the throttle logic may be used at all
// TRIP_SUPPORTED enables the trip latch and is reported in the trip register
module thermal_throttle_and_trip #(
  parameter logic THROTTLE_CAPABLE = 1'b1,
  parameter logic TRIP_SUPPORTED   = 1'b1
) (
  input  wire logic        CLK,          // 10 MHz clock
  input  wire logic        RESET_N,      // async cold reset, active low
  input  wire logic        POWER_GOOD,   // power good pin
  input  wire logic [10:0] TEMP_IN,      // control temperature from calc circuit
  input  wire logic        PKG_C1,       // package in C1
  input  wire logic        PKG_C6,       // package in C6
  input  wire logic        HOT_IND_N_I,  // hot indication pin level
  output logic             HOT_IND_N_O,  // hot pin output value, always low
  output logic             HOT_IND_N_OE_N, // low while pulling the pin low
  output logic             THROTTLE_ACT, // throttle active
  output logic [2:0]       PSTATE_LIMIT, // perf-state cap for all cores
  output logic             TRIP_N,       // trip output, active low
  output logic             CLK_GATE,     // gate off nearly all clocks
  output logic [7:0]       VID_CODE,     // voltage identification code
  output logic [10:0]      SENSOR_TEMP,  // temperature to sideband interface
  output logic [1:0]       SENSOR_MODE,  // bit0 100 kHz, bit1 400 kHz allowed
  input  wire logic [7:0]  ADDR,         // register address
  input  wire logic [31:0] WDATA,        // write data
  input  wire logic        WR,           // write strobe
  input  wire logic        RD,           // read strobe
  output logic [31:0]      RDATA,        // read data, cycle after strobe
  output logic             IRQ           // level interrupt
);
  // state copy and its next value
  thermal_pkg::therm_st_t    st_reg;
  thermal_pkg::therm_st_t    st_next;
  // decoded bus request
  thermal_pkg::bus_req_t     req;
  thermal_pkg::temp_t        temp_s;
  // condition terms of the throttle machine
  logic                      hot_ext;
  logic                      allow;
  logic                      at_limit;
  logic                      below_hyst;
  logic                      cause_int;
  logic [3:0]                ev;
  logic [11:0]               low_mark;

  // word select decode shared by read and write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign req = '{we: WR, re: RD, addr: ADDR, wdata: WDATA};

  // next state of everything
  always_comb begin
    st_next = st_reg;
    temp_s = TEMP_IN;
    st_next.temp = temp_s; // sampled each cycle, same-domain source
    // pin and power good pass two flops; own drive is delayed alongside the pin
    st_next.hot_s1 = HOT_IND_N_I;
    st_next.hot_s2 = st_reg.hot_s1;
    st_next.pg_s1 = POWER_GOOD;
    st_next.pg_s2 = st_reg.pg_s1;
    st_next.oe_d1 = st_reg.hot_oe_n;
    st_next.oe_d2 = st_reg.oe_d1;

    // pin seen low from outside only when we are not the one pulling it,
    // nor were in the two cycles the synchroniser needs to see our release
    hot_ext = !st_reg.hot_s2 && st_reg.hot_oe_n && st_reg.oe_d1 && st_reg.oe_d2;

    // limit and hysteresis compares, all in 8.3
    at_limit = (st_reg.temp >= st_reg.limit);
    low_mark = {1'b0, st_reg.limit} - {5'h00, st_reg.hyst, 3'h0};
    below_hyst = low_mark[11] || ({1'b0, st_reg.temp} < low_mark);

    // entry is only allowed with every enabling condition true
    allow = THROTTLE_CAPABLE && st_reg.en && st_reg.pg_s2 && st_reg.trip_n
            && !PKG_C1 && !PKG_C6;

    // event pulses default to none
    cause_int = 1'b0;
    ev = 4'h0;
    // hysteresis arm flag
    if (at_limit) begin
      st_next.armed = 1'b1;
    end else if (below_hyst) begin
      st_next.armed = 1'b0;
    end

    // throttle state machine
    //   normal:   waits for the enabling conditions plus a hot cause
    //   throttle: perf cap applied; leaves on hysteresis, pin release or enable clear
    //   trip:     sticky until cold reset; nothing written or cooled releases it
    case (st_reg.state)
      thermal_pkg::ST_NORMAL: begin
        if (allow && (at_limit || hot_ext)) begin
          st_next.state = thermal_pkg::ST_THROTTLE;
          st_next.internal = at_limit;
          ev[`IRQ_ENTER_BIT] = 1'b1;
        end
      end
      thermal_pkg::ST_THROTTLE: begin
        if (!st_reg.en && !hot_ext) begin
          st_next.state = thermal_pkg::ST_NORMAL;
        end else if (!st_reg.en) begin
          st_next.state = thermal_pkg::ST_THROTTLE;
        end else if (!at_limit && !st_next.armed && !hot_ext) begin
          st_next.state = thermal_pkg::ST_NORMAL;
        end
        if (at_limit) begin
          st_next.internal = 1'b1;
        end
        if (st_next.state == thermal_pkg::ST_NORMAL) begin
          st_next.internal = 1'b0;
          ev[`IRQ_EXIT_BIT] = 1'b1;
        end
      end
      thermal_pkg::ST_TRIP: begin
        st_next.state = thermal_pkg::ST_TRIP;
      end
      default: st_next.state = thermal_pkg::ST_NORMAL;
    endcase
    // trip overrides everything, only reset leaves it
    if (TRIP_SUPPORTED && st_reg.temp >= `DAMAGE_TEMP && st_reg.state != thermal_pkg::ST_TRIP) begin
      st_next.state = thermal_pkg::ST_TRIP;
      st_next.internal = 1'b0;
      ev[`IRQ_TRIP_BIT] = 1'b1;
    end
    if (hot_ext && st_reg.hot_oe_n && st_reg.state == thermal_pkg::ST_NORMAL) begin
      ev[`IRQ_HOT_BIT] = 1'b1;
    end

    // own pin drive only for an internally caused throttle
    cause_int = (st_next.state == thermal_pkg::ST_THROTTLE) && st_next.internal;
    // register writes
    if (req.we) begin
      if (hit(req.addr, `ADDR_THERMAL_CONTROL)) begin
        st_next.en = req.wdata[`CTL_EN_BIT];
        // other fields frozen while throttling
        if (st_reg.state != thermal_pkg::ST_THROTTLE) begin
          st_next.limit = {req.wdata[`CTL_LIMIT_LSB +: 7], 4'h0};
          st_next.hyst = req.wdata[`CTL_HYST_LSB +: 4];
          st_next.pstate_lim = req.wdata[`CTL_PSTATE_LSB +: 3];
        end
      end else if (hit(req.addr, `ADDR_SENSOR_IF)) begin
        // high speed mode has no bit and cannot be selected
        st_next.sif_mode = req.wdata[1:0];
        if (req.wdata[1:0] == 2'h0) begin
          st_next.sif_mode = `RST_SIF;
        end
      end else if (hit(req.addr, `ADDR_INT_STATUS)) begin
        st_next.irq_sts = st_reg.irq_sts & ~req.wdata[3:0];
      end else if (hit(req.addr, `ADDR_INT_MASK)) begin
        st_next.irq_msk = req.wdata[3:0];
      end
    end
    st_next.irq_sts = st_next.irq_sts | ev; // set beats clear
    // register reads
    st_next.rdata = 32'h0000_0000;
    if (req.re) begin
      if (hit(req.addr, `ADDR_THERMAL_CONTROL)) begin
        st_next.rdata[`CTL_EN_BIT] = st_reg.en;
        st_next.rdata[`CTL_ACT_BIT] = (st_reg.state == thermal_pkg::ST_THROTTLE);
        st_next.rdata[`CTL_HOT_BIT] = !st_reg.hot_s2;
        st_next.rdata[`CTL_LIMIT_LSB +: 7] = st_reg.limit[10:4];
        st_next.rdata[`CTL_HYST_LSB +: 4] = st_reg.hyst;
        st_next.rdata[`CTL_PSTATE_LSB +: 3] = st_reg.pstate_lim;
      end else if (hit(req.addr, `ADDR_CAPABILITY)) begin
        st_next.rdata[`CAP_THROTTLE_BIT] = THROTTLE_CAPABLE;
      end else if (hit(req.addr, `ADDR_TRIP_STATUS)) begin
        st_next.rdata[`TRIP_SUPPORT_BIT] = TRIP_SUPPORTED;
        st_next.rdata[`TRIP_STATE_BIT] = (st_reg.state == thermal_pkg::ST_TRIP);
      end else if (hit(req.addr, `ADDR_TEMP_REPORT)) begin
        st_next.rdata[`TEMP_LSB +: 11] = st_reg.temp;
      end else if (hit(req.addr, `ADDR_SENSOR_IF)) begin
        st_next.rdata[1:0] = st_reg.sif_mode;
      end else if (hit(req.addr, `ADDR_INT_STATUS)) begin
        st_next.rdata[3:0] = st_reg.irq_sts;
      end else if (hit(req.addr, `ADDR_INT_MASK)) begin
        st_next.rdata[3:0] = st_reg.irq_msk;
      end
    end
    // registered outputs
    st_next.irq = |(st_next.irq_sts & st_next.irq_msk);
    st_next.hot_oe_n = !cause_int;
    st_next.limit_act = (st_next.state == thermal_pkg::ST_THROTTLE);
    st_next.trip_n = (st_next.state != thermal_pkg::ST_TRIP);
    st_next.gate = (st_next.state == thermal_pkg::ST_TRIP);
    st_next.voltage_identification_code = (st_next.state == thermal_pkg::ST_TRIP) ? `LOW_VID : 8'h00;
  end

  // state register, constants only under reset
  // pin synchronisers and own-drive delays reset to the released level
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= '{
        state:      thermal_pkg::ST_NORMAL,
        en:         1'b0,
        pstate_lim: `RST_PSTATE,
        limit:      `RST_LIMIT,
        hyst:       `RST_HYST,
        armed:      1'b0,
        internal:   1'b0,
        sif_mode:   `RST_SIF,
        irq_sts:    4'h0,
        irq_msk:    `RST_IRQ_MASK,
        rdata:      32'h0000_0000,
        hot_s1:     1'b1,
        hot_s2:     1'b1,
        pg_s1:      1'b0,
        pg_s2:      1'b0,
        irq:        1'b0,
        hot_oe_n:   1'b1,
        oe_d1:      1'b1,
        oe_d2:      1'b1,
        trip_n:     1'b1,
        gate:       1'b0,
        voltage_identification_code:        8'h00,
        limit_act:  1'b0,
        temp:       11'h000
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops; temperature scale interpretation is downstream
  // hot pin: value fixed low, the enable alone pulls the wire
  assign HOT_IND_N_O = 1'b0;
  assign HOT_IND_N_OE_N = st_reg.hot_oe_n;

  // throttle and trip status
  assign THROTTLE_ACT = st_reg.limit_act;
  assign PSTATE_LIMIT = st_reg.pstate_lim;
  assign TRIP_N = st_reg.trip_n;
  assign CLK_GATE = st_reg.gate;
  assign VID_CODE = st_reg.voltage_identification_code;

  // sideband copy and register port
  assign SENSOR_TEMP = st_reg.temp;
  assign SENSOR_MODE = st_reg.sif_mode;
  assign RDATA = st_reg.rdata;
  assign IRQ = st_reg.irq;
endmodule

// *** testbench/thermal_throttle_and_trip_monitor.sv ***
// port checker for the thermal throttle and trip block
`timescale 1ns/1ns
module thermal_throttle_and_trip_monitor (
  input wire logic        CLK,            // clock
  input wire logic        RESET_N,        // cold reset
  input wire logic [10:0] TEMP_IN,        // temperature in
  input wire logic        PKG_C1,         // package c1
  input wire logic        PKG_C6,         // package c6
  input wire logic        HOT_IND_N_I,    // hot pin level
  input wire logic        HOT_IND_N_O,    // hot pin drive value
  input wire logic        HOT_IND_N_OE_N, // hot pin enable
  input wire logic        THROTTLE_ACT,   // throttling
  input wire logic [2:0]  PSTATE_LIMIT,   // perf-state cap
  input wire logic        TRIP_N,         // trip out
  input wire logic        CLK_GATE,       // clock gate
  input wire logic [7:0]  VID_CODE,       // voltage code
  input wire logic [10:0] SENSOR_TEMP     // sensor copy
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // open drain pin only ever pulls low, and only while throttling
  AST_HOT_DRIVE_LOW: assert property (HOT_IND_N_O == 1'b0)
    else $error("hot pin drive value not low");
  AST_HOT_OE_ACTIVE: assert property (!HOT_IND_N_OE_N |-> THROTTLE_ACT)
    else $error("hot pin pulled without throttling");
  AST_PSTATE_HELD: assert property (THROTTLE_ACT && $past(THROTTLE_ACT) |-> $stable(PSTATE_LIMIT))
    else $error("perf-state cap moved while throttling");
  AST_ENTRY_GATED: assert property ($rose(THROTTLE_ACT) |-> !$past(PKG_C1) && !$past(PKG_C6) && $past(TRIP_N))
    else $error("throttle entered in c-state or trip");
  AST_EXT_HOLD: assert property ((!HOT_IND_N_I && HOT_IND_N_OE_N)[*3] ##0 THROTTLE_ACT |=> THROTTLE_ACT)
    else $error("throttle left while hot pin held externally");
  // trip entry, its outputs and its latch
  AST_TRIP_ENTRY: assert property (TEMP_IN >= 11'h7f8 |-> ##[1:4] !TRIP_N)
    else $error("no trip at damage temperature");
  AST_TRIP_OUTPUTS: assert property (!TRIP_N |-> CLK_GATE && VID_CODE == 8'h7f)
    else $error("trip without gated clocks and low voltage code");
  AST_TRIP_LATCHED: assert property (!TRIP_N |=> !TRIP_N)
    else $error("trip released without reset");
  AST_SENSOR_COPY: assert property ($past(RESET_N) |-> SENSOR_TEMP == $past(TEMP_IN))
    else $error("sensor temperature not one cycle behind input");
  cover property ($rose(THROTTLE_ACT));
  cover property ($fell(HOT_IND_N_OE_N));
  cover property ($fell(TRIP_N));
endmodule
bind thermal_throttle_and_trip thermal_throttle_and_trip_monitor thermal_throttle_and_trip_monitor_inst (
  .CLK, .RESET_N, .TEMP_IN, .PKG_C1, .PKG_C6, .HOT_IND_N_I, .HOT_IND_N_O, .HOT_IND_N_OE_N,
  .THROTTLE_ACT, .PSTATE_LIMIT, .TRIP_N, .CLK_GATE, .VID_CODE, .SENSOR_TEMP);

// *** testbench/thermal_platform_model.sv ***
// platform model: hot pin pull-up and chipset reacting to trip
`timescale 1ns/1ns
module thermal_platform_model (
  input  wire logic CLK,        // clock
  input  wire logic RESET_N,    // cold reset
  input  wire logic oe_n,       // device pulls pin low
  input  wire logic hot_req,    // platform pulls pin low
  input  wire logic trip_n,     // trip output
  output logic      pin_n,      // resolved pin level
  output logic      power_good  // power good to device
);
  // open drain wire with pull-up
  assign pin_n = (!oe_n || hot_req) ? 1'b0 : 1'b1;
  // chipset powers off on trip, power returns with cold reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) power_good <= 1'b1;
    else if (!trip_n) power_good <= 1'b0;
  end
endmodule

// *** testbench/thermal_throttle_and_trip_bench.sv ***
// self-checking bench for the thermal throttle and trip block
`timescale 1ns/1ns
module thermal_throttle_and_trip_bench;
  logic        clk, reset_n, wr, rd, hot_req, act, oe_n, trip_n, gate, irq, pg, pin_n, rd_seen;
  logic [1:0]  cst, smode;
  logic [2:0]  plim;
  logic [7:0]  addr, voltage_identification_code;
  logic [10:0] temp_in, temp_out, t;
  logic [31:0] wdata, rdata;
  logic [31:0] expq[$];
  logic [10:0] hys_t[3] = '{11'h3ff, 11'h3f0, 11'h3ef};
  logic        hys_a[3] = '{1'b1, 1'b1, 1'b0};
  integer      seed;
  int          error_cnt, checked;
  thermal_throttle_and_trip thermal_throttle_and_trip_inst (
    .CLK(clk), .RESET_N(reset_n), .POWER_GOOD(pg), .TEMP_IN(temp_in), .PKG_C1(cst[0]), .PKG_C6(cst[1]),
    .HOT_IND_N_I(pin_n), .HOT_IND_N_O(), .HOT_IND_N_OE_N(oe_n), .THROTTLE_ACT(act), .PSTATE_LIMIT(plim),
    .TRIP_N(trip_n), .CLK_GATE(gate), .VID_CODE(voltage_identification_code), .SENSOR_TEMP(temp_out), .SENSOR_MODE(smode),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
  thermal_platform_model thermal_platform_model_inst (
    .CLK(clk), .RESET_N(reset_n), .oe_n(oe_n), .hot_req(hot_req), .trip_n(trip_n), .pin_n(pin_n),
    .power_good(pg));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  // read data compared mid-cycle after the strobe, oldest note first
  always @(negedge clk) begin
    if (rd_seen) chk("rdata", rdata, expq.pop_front());
    rd_seen <= rd;
  end
  // main sequence
  initial begin
    {reset_n, wr, rd, hot_req, rd_seen, cst, addr, wdata, temp_in} = '0;
    seed = 32'hf46259e3;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(8'h04, 32'h0000_0400);
    rd_reg(8'h08, 32'h0000_0020);
    rd_reg(8'h1c, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr_reg(8'h10, 32'(m));
      rd_reg(8'h10, (m == 0) ? 32'h1 : 32'(m));
    end
    chk("sensor mode", smode, 2'h2);
    wr_reg(8'h18, 32'h1);
    wr_reg(8'h00, 32'h5240_0001);
    rd_reg(8'h00, 32'h5240_0001);
    t = 11'h400 + 11'($random(seed) & 32'hff);
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      cst <= 2'(1 << c);
      temp_in <= t;
      cyc(6);
      chk("act in c-state", act, 1'b0);
    end
    @(posedge clk);
    cst <= 2'b00;
    cyc(4);
    chk("act", act, 1'b1);
    chk("plim", plim, 3'h5);
    chk("oe_n", oe_n, 1'b0);
    chk("irq", irq, 1'b1);
    chk("sensor temp", temp_out, t);
    rd_reg(8'h0c, {t, 21'h0});
    wr_reg(8'h14, 32'hf);
    cyc(2);
    chk("irq cleared", irq, 1'b0);
    foreach (hys_t[i]) begin
      @(posedge clk);
      temp_in <= hys_t[i];
      cyc(6);
      chk("act hysteresis", act, hys_a[i]);
    end
    rd_reg(8'h14, 32'h2);
    wr_reg(8'h14, 32'hf);
    @(posedge clk);
    temp_in <= t;
    cyc(4);
    wr_reg(8'h00, 32'h5240_0000);
    cyc(4);
    chk("act enable off", act, 1'b0);
    @(posedge clk);
    temp_in <= 11'h100;
    wr_reg(8'h00, 32'h5240_0001);
    @(posedge clk);
    hot_req <= 1'b1;
    cyc(6);
    chk("act external", act, 1'b1);
    chk("oe_n external", oe_n, 1'b1);
    wr_reg(8'h00, 32'h5240_0000);
    cyc(6);
    chk("act held", act, 1'b1);
    @(posedge clk);
    hot_req <= 1'b0;
    cyc(6);
    chk("act released", act, 1'b0);
    @(posedge clk);
    temp_in <= 11'h7f8;
    cyc(5);
    chk("trip_n", trip_n, 1'b0);
    chk("clock gate", gate, 1'b1);
    chk("vid", voltage_identification_code, 8'h7f);
    rd_reg(8'h08, 32'h0000_0021);
    wr_reg(8'h08, 32'h0);
    @(posedge clk);
    temp_in <= 11'h0;
    cyc(5);
    chk("trip held", trip_n, 1'b0);
    chk("chipset power", pg, 1'b0);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    cyc(3);
    chk("trip after reset", trip_n, 1'b1);
    stop_test;
  end
endmodule
